/* File: rtl/opm_pkg.sv */
// constants, types and timing tables for the optical pulse measurement block
// assumes a 100 MHz system clock and a byte-wide internal register port
package opm_pkg;

    // ******************************************************************
    // register map
    // ******************************************************************
    localparam logic [7:0] ADDR_RED_LOW   = 8'h32;
    localparam logic [7:0] ADDR_RED_HIGH  = 8'h33;
    localparam logic [7:0] ADDR_CANCEL    = 8'h34;
    localparam logic [7:0] ADDR_AVERAGE   = 8'h35;
    localparam logic [7:0] ADDR_PW_PERIOD = 8'h36;

    localparam logic [7:0] RST_RED_LOW    = 8'h00;
    localparam logic [7:0] RST_RED_HIGH   = 8'h00;
    localparam logic [7:0] RST_CANCEL     = 8'h00;
    localparam logic [7:0] RST_AVERAGE    = 8'h0A;
    localparam logic [7:0] RST_PW_PERIOD  = 8'h42;
    localparam logic [7:0] READ_UNMAPPED  = 8'h00;

    // ******************************************************************
    // field positions
    // ******************************************************************
    localparam int RED_MSB_BIT     = 0;
    localparam int IR_CANCEL_BIT   = 2;
    localparam int RED_CANCEL_BIT  = 0;
    localparam int AVG_LSB         = 4;
    localparam int PW_LSB          = 4;
    localparam int PERIOD_LSB      = 0;
    localparam int FIELD_W         = 3;
    localparam int RED_CODE_W      = 9;
    localparam int DATA_W          = 18;
    localparam int AVG_LOG_MAX     = 5;

    localparam logic [RED_CODE_W-1:0] RED_CODE_OFF = 9'h000;
    localparam logic [FIELD_W-1:0]    AVG_SEL_MAX  = 3'h5;
    localparam logic [FIELD_W-1:0]    PW_LOW_RES   = 3'h3;
    localparam logic [FIELD_W-1:0]    AVG_SEL_ONE  = 3'h0;
    localparam logic [FIELD_W-1:0]    AVG_SEL_TWO  = 3'h1;
    localparam logic [4:0]            RES_16       = 5'h10;
    localparam logic [4:0]            RES_17       = 5'h11;
    localparam logic [4:0]            RES_18       = 5'h12;

    localparam logic LED_IR  = 1'b0;
    localparam logic LED_RED = 1'b1;

    // ******************************************************************
    // timing
    // ******************************************************************
    localparam int unsigned CLK_PERIOD_NS = 10;

    typedef int unsigned opm_tab_t [8];

    localparam opm_tab_t PERIOD_NS = '{312500, 625000, 1000000, 1250000,
                                       2500000, 5000000, 10000000,
                                       20000000};
    // reserved pulse codes 0 and 1 fall back to the shortest pulse
    localparam opm_tab_t PULSE_NS  = '{65000, 65000, 65000, 130000,
                                       247000, 481000, 949000, 949000};

    function automatic opm_tab_t opm_cycles(opm_tab_t ns);
        opm_tab_t c;
        for (int i = 0; i < 8; i++) begin
            c[i] = (ns[i] / CLK_PERIOD_NS == 0) ? 1 : ns[i] / CLK_PERIOD_NS;
        end
        return c;
    endfunction

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_PULSE_A = 2'b01,
        ST_PULSE_B = 2'b10,
        ST_WAIT    = 2'b11
    } opm_state_t;

    typedef struct packed {
        logic              led;
        logic [DATA_W-1:0] data;
    } opm_entry_t;

endpackage

/* File: rtl/opm_average.sv */
// one channel of sample averaging: sums 2**avgLog samples, emits the mean
// assumes sampleValid is a one-cycle strobe and avgLog is at most MAX_LOG
`timescale 1ns/100ps
`default_nettype none
module opm_average
    import opm_pkg::*;
#(
    parameter int DW      = DATA_W,
    parameter int MAX_LOG = AVG_LOG_MAX
) (
    input  wire logic          clk,
    input  wire logic          resetn,
    input  wire logic          ce,
    input  wire logic          clear,
    input  wire logic [2:0]    avgLog,
    input  wire logic          sampleValid,
    input  wire logic [DW-1:0] sampleData,
    output logic               resultValid,
    output logic [DW-1:0]      resultData
);
    localparam int SW = DW + MAX_LOG;

    if (DW < 1 || MAX_LOG < 1 || MAX_LOG > 7) begin : g_chk
        $error("opm_average: unsupported width or depth");
    end

    logic [SW-1:0]      sum;
    logic [MAX_LOG-1:0] count;
    logic [SW-1:0]      next_sum;
    logic [MAX_LOG-1:0] next_count;
    logic               next_resultValid;
    logic [DW-1:0]      next_resultData;

    // ******************************************************************
    // accumulate and emit
    // ******************************************************************
    always_comb begin
        logic [SW-1:0]      total;
        logic [MAX_LOG-1:0] last;
        total = sum + SW'(sampleData);
        last  = MAX_LOG'((1 << avgLog) - 1);
        next_sum         = sum;
        next_count       = count;
        next_resultValid = 1'b0;
        next_resultData  = resultData;
        if (clear) begin
            next_sum   = '0;
            next_count = '0;
        end else if (sampleValid) begin
            if (count == last) begin
                next_resultValid = 1'b1;
                next_resultData  = DW'(total >> avgLog);
                next_sum         = '0;
                next_count       = '0;
            end else begin
                next_sum   = total;
                next_count = count + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sum         <= '0;
            count       <= '0;
            resultValid <= 1'b0;
            resultData  <= '0;
        end else if (ce) begin
            sum         <= next_sum;
            count       <= next_count;
            resultValid <= next_resultValid;
            resultData  <= next_resultData;
        end
    end
endmodule
`default_nettype wire

/* File: rtl/opm_config.sv */
// configuration registers and pulse sequencer of the optical measurement
// assumes a byte register port behind the serial bus and a converter that
// returns one sampleValid strobe per LED pulse, inside that pulse
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - Low eight bits of red drive code live in the first current register.
// - Ninth, top bit of red drive code is bit 0 of second register.
// - Nine-bit red code gives 512 drive levels, all-ones is full current.
// - Red code zero, the reset value, keeps the red LED dark.
// - Infrared cancel bit applies half-scale offset during infrared pulses.
// - Red cancel bit applies half-scale offset during red pulses.
// - Averaging field picks 1, 2, 4, 8, 16 or 32 samples per result.
// - One FIFO entry is written for every N measured samples.
// - Pulse field sets LED pulse length from 65 to 949 microseconds.
// - Period field picks 0.3125 to 20 ms; single mode samples once.
// - Dual mode takes two samples per period, one per LED.
// - Resolution is 16, 17 or 18 bits by pulse width and averaging.
// - First pulse is infrared unless swapped; second pulse uses other LED.
module opm_config
    import opm_pkg::*;
#(
    parameter int       PERIOD_W   = 21,
    parameter int       PULSE_W    = 17,
    parameter opm_tab_t PERIOD_CYC = opm_cycles(PERIOD_NS),
    parameter opm_tab_t PULSE_CYC  = opm_cycles(PULSE_NS)
) (
    input  wire logic                  clk,
    input  wire logic                  resetn,
    input  wire logic                  ce,
    input  wire logic [7:0]            regAddr,
    input  wire logic                  regWrEn,
    input  wire logic [7:0]            regWrData,
    input  wire logic                  regRdEn,
    output logic [7:0]                 regRdData,
    input  wire logic                  measureEnable,
    input  wire logic                  dual_led_mode,
    input  wire logic                  led_order_swap,
    input  wire logic                  sampleValid,
    input  wire logic [DATA_W-1:0]     sampleData,
    output logic                       infrared_led_output,
    output logic                       red_led_output,
    output logic [RED_CODE_W-1:0]      redDriveCode,
    output logic                       infraredCancelActive,
    output logic                       redCancelActive,
    output logic                       measuring,
    output logic                       fifoWrValid,
    output opm_entry_t                 fifoEntry,
    output logic [4:0]                 resolutionBits
);
    // ******************************************************************
    // elaboration checks
    // ******************************************************************
    for (genvar i = 0; i < 8; i++) begin : g_chk
        if (PERIOD_CYC[i] >= (64'd1 << PERIOD_W) ||
            PULSE_CYC[i] >= (64'd1 << PULSE_W) ||
            PULSE_CYC[i] == 0 || 2 * PULSE_CYC[i] >= PERIOD_CYC[7]) begin : g_bad
            $error("opm_config: timing table does not fit counters");
        end
    end

    // ******************************************************************
    // registers
    // ******************************************************************
    logic [7:0] red_led_current_low;
    logic [7:0] red_led_current_high;
    logic [7:0] pulse_offset_cancel;
    logic [7:0] pulse_sample_average;
    logic [7:0] pulse_width_and_period;
    logic [7:0] next_red_led_current_low;
    logic [7:0] next_red_led_current_high;
    logic [7:0] next_pulse_offset_cancel;
    logic [7:0] next_pulse_sample_average;
    logic [7:0] next_pulse_width_and_period;
    logic [7:0] next_regRdData;

    logic [FIELD_W-1:0] average_count_select;
    logic [FIELD_W-1:0] led_pulse_duration;
    logic [FIELD_W-1:0] sample_period_select;
    logic [RED_CODE_W-1:0] red_code;

    assign average_count_select = pulse_sample_average[AVG_LSB +: FIELD_W];
    assign led_pulse_duration   = pulse_width_and_period[PW_LSB +: FIELD_W];
    assign sample_period_select =
        pulse_width_and_period[PERIOD_LSB +: FIELD_W];
    assign red_code = {red_led_current_high[RED_MSB_BIT], red_led_current_low};
    assign redDriveCode = red_code;

    always_comb begin
        next_red_led_current_low    = red_led_current_low;
        next_red_led_current_high   = red_led_current_high;
        next_pulse_offset_cancel    = pulse_offset_cancel;
        next_pulse_sample_average   = pulse_sample_average;
        next_pulse_width_and_period = pulse_width_and_period;
        next_regRdData              = regRdData;
        if (regWrEn) begin
            if (regAddr == ADDR_RED_LOW) begin
                next_red_led_current_low = regWrData;
            end else if (regAddr == ADDR_RED_HIGH) begin
                next_red_led_current_high = regWrData;
            end else if (regAddr == ADDR_CANCEL) begin
                next_pulse_offset_cancel = regWrData;
            end else if (regAddr == ADDR_AVERAGE) begin
                next_pulse_sample_average = regWrData;
            end else if (regAddr == ADDR_PW_PERIOD) begin
                next_pulse_width_and_period = regWrData;
            end
        end
        if (regRdEn) begin
            if (regAddr == ADDR_RED_LOW) begin
                next_regRdData = red_led_current_low;
            end else if (regAddr == ADDR_RED_HIGH) begin
                next_regRdData = red_led_current_high;
            end else if (regAddr == ADDR_CANCEL) begin
                next_regRdData = pulse_offset_cancel;
            end else if (regAddr == ADDR_AVERAGE) begin
                next_regRdData = pulse_sample_average;
            end else if (regAddr == ADDR_PW_PERIOD) begin
                next_regRdData = pulse_width_and_period;
            end else begin
                next_regRdData = READ_UNMAPPED;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            red_led_current_low    <= RST_RED_LOW;
            red_led_current_high   <= RST_RED_HIGH;
            pulse_offset_cancel    <= RST_CANCEL;
            pulse_sample_average   <= RST_AVERAGE;
            pulse_width_and_period <= RST_PW_PERIOD;
            regRdData              <= READ_UNMAPPED;
        end else if (ce) begin
            red_led_current_low    <= next_red_led_current_low;
            red_led_current_high   <= next_red_led_current_high;
            pulse_offset_cancel    <= next_pulse_offset_cancel;
            pulse_sample_average   <= next_pulse_sample_average;
            pulse_width_and_period <= next_pulse_width_and_period;
            regRdData              <= next_regRdData;
        end
    end

    // ******************************************************************
    // pulse sequencer
    // ******************************************************************
    opm_state_t          state;
    opm_state_t          next_state;
    logic [PERIOD_W-1:0] periodCnt;
    logic [PERIOD_W-1:0] next_periodCnt;
    logic [PULSE_W-1:0]  pulseCnt;
    logic [PULSE_W-1:0]  next_pulseCnt;
    logic                slotLed;
    logic                next_slotLed;

    always_comb begin
        logic [PERIOD_W-1:0] periodLoad;
        logic [PULSE_W-1:0]  pulseLoad;
        periodLoad = PERIOD_W'(PERIOD_CYC[sample_period_select] - 1);
        pulseLoad  = PULSE_W'(PULSE_CYC[led_pulse_duration] - 1);
        next_state     = state;
        next_periodCnt = periodCnt;
        next_pulseCnt  = pulseCnt;
        next_slotLed   = slotLed;
        if (!measureEnable) begin
            next_state = ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    next_state     = ST_PULSE_A;
                    next_periodCnt = periodLoad;
                    next_pulseCnt  = pulseLoad;
                    next_slotLed   = led_order_swap ? LED_RED : LED_IR;
                end
                ST_PULSE_A, ST_PULSE_B: begin
                    next_periodCnt = periodCnt - 1'b1;
                    next_pulseCnt  = pulseCnt - 1'b1;
                    if (pulseCnt == '0) begin
                        if (state == ST_PULSE_A && dual_led_mode) begin
                            next_state    = ST_PULSE_B;
                            next_pulseCnt = pulseLoad;
                            next_slotLed  = ~slotLed;
                        end else begin
                            next_state = ST_WAIT;
                        end
                    end
                end
                ST_WAIT: begin
                    next_periodCnt = periodCnt - 1'b1;
                    if (periodCnt == '0) begin
                        next_state     = ST_PULSE_A;
                        next_periodCnt = periodLoad;
                        next_pulseCnt  = pulseLoad;
                        next_slotLed   = led_order_swap ? LED_RED : LED_IR;
                    end
                end
                default: next_state = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state     <= ST_IDLE;
            periodCnt <= '0;
            pulseCnt  <= '0;
            slotLed   <= LED_IR;
        end else if (ce) begin
            state     <= next_state;
            periodCnt <= next_periodCnt;
            pulseCnt  <= next_pulseCnt;
            slotLed   <= next_slotLed;
        end
    end

    logic pulseOn;
    assign pulseOn   = (state == ST_PULSE_A) || (state == ST_PULSE_B);
    assign measuring = (state != ST_IDLE);
    assign infrared_led_output = pulseOn && (slotLed == LED_IR);
    assign red_led_output = pulseOn && (slotLed == LED_RED) &&
                            (red_code != RED_CODE_OFF);
    assign infraredCancelActive = infrared_led_output &&
                                  pulse_offset_cancel[IR_CANCEL_BIT];
    assign redCancelActive = pulseOn && (slotLed == LED_RED) &&
                             pulse_offset_cancel[RED_CANCEL_BIT];

    // ******************************************************************
    // averaging and result output
    // ******************************************************************
    logic [2:0]        avgLog;
    logic [1:0]        chValid;
    logic [1:0]        chResValid;
    logic [DATA_W-1:0] chResData [2];
    logic              next_fifoWrValid;
    opm_entry_t        next_fifoEntry;
    logic [4:0]        next_resolutionBits;

    assign avgLog = (average_count_select > AVG_SEL_MAX) ?
                    AVG_SEL_MAX : average_count_select;

    for (genvar c = 0; c < 2; c++) begin : g_ch
        // samples belong to the LED of the pulse just fired
        assign chValid[c] = sampleValid && (slotLed == 1'(c));
        opm_average #(
            .DW      (DATA_W),
            .MAX_LOG (AVG_LOG_MAX)
        ) u_avg (
            .clk         (clk),
            .resetn      (resetn),
            .ce          (ce),
            .clear       (!measureEnable),
            .avgLog      (avgLog),
            .sampleValid (chValid[c]),
            .sampleData  (sampleData),
            .resultValid (chResValid[c]),
            .resultData  (chResData[c])
        );
    end

    always_comb begin
        logic [DATA_W-1:0] mask;
        next_resolutionBits = RES_18;
        if (led_pulse_duration <= PW_LOW_RES) begin
            if (average_count_select == AVG_SEL_ONE) begin
                next_resolutionBits = RES_16;
            end else if (average_count_select == AVG_SEL_TWO) begin
                next_resolutionBits = RES_17;
            end
        end
        mask = ~DATA_W'((1 << (RES_18 - next_resolutionBits)) - 1);
        next_fifoWrValid = |chResValid;
        next_fifoEntry   = fifoEntry;
        if (chResValid[LED_RED]) begin
            next_fifoEntry = '{led: LED_RED, data: chResData[1] & mask};
        end else if (chResValid[LED_IR]) begin
            next_fifoEntry = '{led: LED_IR, data: chResData[0] & mask};
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fifoWrValid    <= 1'b0;
            fifoEntry      <= '0;
            resolutionBits <= RES_18;
        end else if (ce) begin
            fifoWrValid    <= next_fifoWrValid;
            fifoEntry      <= next_fifoEntry;
            resolutionBits <= next_resolutionBits;
        end
    end
endmodule
`default_nettype wire

/* File: verif/opm_config_monitor.sv */
// port checker for opm_config
// assumes ce held high while the block runs
`timescale 1ns/100ps
`default_nettype none
module opm_config_monitor
    import opm_pkg::*;
(
    input wire logic                  clk,
    input wire logic                  resetn,
    input wire logic                  ce,
    input wire logic [7:0]            regAddr,
    input wire logic                  regWrEn,
    input wire logic [7:0]            regWrData,
    input wire logic                  measureEnable,
    input wire logic                  sampleValid,
    input wire logic                  infrared_led_output,
    input wire logic                  red_led_output,
    input wire logic [RED_CODE_W-1:0] redDriveCode,
    input wire logic                  infraredCancelActive,
    input wire logic                  redCancelActive,
    input wire logic                  measuring,
    input wire logic                  fifoWrValid,
    input wire opm_entry_t            fifoEntry,
    input wire logic [4:0]            resolutionBits
);
    // ******************************
    // port relations
    // ******************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    a_red_low_map: assert property (
        ce && regWrEn && regAddr == ADDR_RED_LOW
        |=> redDriveCode[7:0] == $past(regWrData))
        else $error("red code low byte not stored");
    a_red_msb_map: assert property (
        ce && regWrEn && regAddr == ADDR_RED_HIGH
        |=> {7'h00, redDriveCode[8]} == ($past(regWrData) & 8'h01))
        else $error("red code top bit not stored");
    a_red_dark_off: assert property (
        red_led_output |-> redDriveCode != RED_CODE_OFF)
        else $error("red pulse with zero code");
    a_ir_cancel_pulse: assert property (
        infraredCancelActive |-> infrared_led_output)
        else $error("infrared cancel outside infrared pulse");
    a_red_cancel_slot: assert property (
        redCancelActive |-> measuring && !infrared_led_output)
        else $error("red cancel outside red slot");
    a_fifo_after_sample: assert property (
        fifoWrValid |-> $past(sampleValid, 2))
        else $error("fifo write without sample");
    a_low_res_bits: assert property (
        fifoWrValid && resolutionBits == RES_16
        |-> fifoEntry.data[1:0] == 2'h0)
        else $error("16 bit result keeps low bits");
    a_idle_when_off: assert property (
        ce && !measureEnable
        |=> !measuring && !infrared_led_output && !red_led_output)
        else $error("sequencer runs while disabled");
    c_fifo_write: cover property (fifoWrValid);
    c_red_pulse: cover property (red_led_output);
    c_red_cancel: cover property (redCancelActive);
endmodule

bind opm_config opm_config_monitor u_mon (
    .clk, .resetn, .ce, .regAddr, .regWrEn, .regWrData, .measureEnable,
    .sampleValid, .infrared_led_output, .red_led_output, .redDriveCode,
    .infraredCancelActive, .redCancelActive, .measuring, .fifoWrValid,
    .fifoEntry, .resolutionBits
);
`default_nettype wire

/* File: verif/opm_converter_model.sv */
// converter model: one result early in each lit LED pulse
// assumes LED outputs change just after rising clk edges
`timescale 1ns/100ps
`default_nettype none
module opm_converter_model
    import opm_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              resetn,
    input  wire logic              irLed,
    input  wire logic              redLed,
    input  wire logic [DATA_W-1:0] level,
    output logic                   sampleValid,
    output logic [DATA_W-1:0]      sampleData
);
    logic prevIr;
    logic prevRed;
    // one strobe per pulse of either LED, inside that pulse
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prevIr <= 1'b0;
            prevRed <= 1'b0;
            sampleValid <= 1'b0;
        end else begin
            prevIr <= irLed;
            prevRed <= redLed;
            sampleValid <= (irLed && !prevIr) || (redLed && !prevRed);
        end
    end
    // data is not held outside the strobe
    assign sampleData = sampleValid ? level : ~level;
endmodule
`default_nettype wire

/* File: verif/optical_pulse_measure_config_tb.sv */
// self-checking bench for opm_config and the converter model
// assumes short timing tables in place of the real ones
`timescale 1ns/100ps
`default_nettype none
module optical_pulse_measure_config_tb
    import opm_pkg::*;
;
    localparam opm_tab_t PD = '{40, 60, 80, 100, 120, 140, 160, 200};
    localparam opm_tab_t PC = '{5, 5, 5, 8, 10, 12, 15, 15};
    localparam logic [DATA_W-1:0] LEVEL = 18'h2A5A7;
    typedef struct packed {logic wr; logic [7:0] a; logic [7:0] d;} opm_row_t;
    opm_row_t rows [12] = '{
        '{1'b0, 8'h32, 8'h00}, '{1'b0, 8'h33, 8'h00}, '{1'b0, 8'h34, 8'h00},
        '{1'b0, 8'h35, 8'h0A}, '{1'b0, 8'h36, 8'h42}, '{1'b0, 8'h37, 8'h00},
        '{1'b1, 8'h37, 8'hFF}, '{1'b0, 8'h37, 8'h00}, '{1'b1, 8'h32, 8'hA5},
        '{1'b1, 8'h33, 8'h01}, '{1'b0, 8'h32, 8'hA5}, '{1'b0, 8'h33, 8'h01}};
    logic clk, resetn, ce, regWrEn, regRdEn, measureEnable, dualMode, swap;
    logic [7:0] regAddr, regWrData, regRdData, got;
    logic sampleValid, irLed, redLed, irCan, redCan, measuring, fifoWrValid;
    logic [DATA_W-1:0] sampleData;
    logic [8:0] redDriveCode;
    logic [4:0] resolutionBits;
    logic first;
    opm_entry_t fifoEntry, lastEntry;
    int n_fail, tests_run, irCnt, redCnt, irCanCnt, redCanCnt, wrCnt, lastRise;

    opm_config #(.PERIOD_CYC(PD), .PULSE_CYC(PC)) dut (
        .clk(clk), .resetn(resetn), .ce(ce), .regAddr(regAddr),
        .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
        .regRdData(regRdData), .measureEnable(measureEnable),
        .dual_led_mode(dualMode), .led_order_swap(swap),
        .sampleValid(sampleValid), .sampleData(sampleData),
        .infrared_led_output(irLed), .red_led_output(redLed),
        .redDriveCode(redDriveCode), .infraredCancelActive(irCan),
        .redCancelActive(redCan), .measuring(measuring),
        .fifoWrValid(fifoWrValid), .fifoEntry(fifoEntry),
        .resolutionBits(resolutionBits));
    opm_converter_model conv (
        .clk(clk), .resetn(resetn), .irLed(irLed), .redLed(redLed),
        .level(LEVEL), .sampleValid(sampleValid), .sampleData(sampleData));

    always #5 clk = ~clk;

    // ******************************
    // tasks
    // ******************************
    task automatic check(string what, logic [31:0] exp, logic [31:0] seen);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(negedge clk);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        @(negedge clk);
        regWrEn = 1'b0;
    endtask
    task automatic rd(logic [7:0] a);
        @(negedge clk);
        regAddr = a;
        regRdEn = 1'b1;
        @(negedge clk);
        regRdEn = 1'b0;
        got = regRdData;
    endtask
    task automatic run(int cyc);
        logic prev;
        prev = 1'b0;
        {irCnt, redCnt, irCanCnt, redCanCnt, wrCnt, lastRise} = '0;
        @(negedge clk);
        measureEnable = 1'b1;
        for (int i = 0; i < cyc; i++) begin
            @(negedge clk);
            if (i == 0) first = irLed;
            if ((irLed | redLed) && !prev) lastRise = i;
            prev = irLed | redLed;
            irCnt += irLed;
            redCnt += redLed;
            irCanCnt += irCan;
            redCanCnt += redCan;
            if (fifoWrValid) begin
                wrCnt++;
                lastEntry = fifoEntry;
            end
        end
        measureEnable = 1'b0;
        repeat (3) @(negedge clk);
    endtask
    task automatic wrap_up();
        if (n_fail == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ******************************
    // sequence
    // ******************************
    initial begin
        {clk, resetn, regWrEn, regRdEn, measureEnable, dualMode, swap} = '0;
        {regAddr, regWrData, n_fail, tests_run} = '0;
        ce = 1'b1;
        repeat (3) @(negedge clk);
        resetn = 1'b1;
        check("resolution", RES_18, resolutionBits);
        check("red code", 9'h000, redDriveCode);
        ce = 1'b0;
        wr(8'h32, 8'h5A);
        ce = 1'b1;
        check("ce hold", 9'h000, redDriveCode);
        foreach (rows[i]) begin
            if (rows[i].wr) wr(rows[i].a, rows[i].d);
            else begin
                rd(rows[i].a);
                check("register", rows[i].d, got);
            end
        end
        check("red code", 9'h1A5, redDriveCode);
        wr(8'h32, 8'hFF);
        check("red code", 9'h1FF, redDriveCode);
        wr(8'h36, 8'h30);
        for (int c = 0; c < 8; c++) begin
            wr(8'h35, {1'b0, c[2:0], 4'hA});
            run(32 * PD[0]);
            check("writes", 32 / ((c > 5) ? 32 : 1 << c), wrCnt);
            check("res", c == 0 ? RES_16 : c == 1 ? RES_17 : RES_18,
                  resolutionBits);
            check("data", LEVEL & ~18'(c == 0 ? 3 : c == 1 ? 1 : 0),
                  lastEntry.data);
            check("led", LED_IR, lastEntry.led);
            check("lit", 32 * PC[3], irCnt);
        end
        wr(8'h35, 8'h0A);
        for (int c = 0; c < 8; c++) begin
            wr(8'h36, {1'b0, c[2:0], 4'h7});
            run(PD[7]);
            check("width", PC[c], irCnt);
            wr(8'h36, {4'h3, 1'b0, c[2:0]});
            run(2 * PD[c]);
            check("period", PD[c], lastRise);
        end
        wr(8'h36, 8'h34);
        dualMode = 1'b1;
        for (int j = 0; j < 3; j++) begin
            wr(8'h32, j == 2 ? 8'h00 : 8'hFF);
            wr(8'h33, 8'h00);
            wr(8'h34, j == 0 ? 8'h05 : j == 1 ? 8'h04 : 8'h01);
            swap = (j == 1);
            run(PD[4]);
            check("first ir", j != 1, first);
            check("ir lit", PC[3], irCnt);
            check("red lit", j == 2 ? 0 : PC[3], redCnt);
            check("ir cancel", j == 2 ? 0 : PC[3], irCanCnt);
            check("red cancel", j == 1 ? 0 : PC[3], redCanCnt);
        end
        wrap_up();
    end
    initial begin
        #1_000_000;
        n_fail++;
        wrap_up();
    end
endmodule
`default_nettype wire
